// [core/snsadc_consts.svh]
// Purpose: Named offsets, field positions, reset values and frame counts
// Assumes: Included by the serial link and register bank design files and by the bench
// Notes: Definitions only
`ifndef SNSADC_CONSTS_SVH
`define SNSADC_CONSTS_SVH

// ==========================================================
// Register byte addresses
`define SNSADC_A_IFCFG 15'h0001
`define SNSADC_A_CLASS 15'h0003
`define SNSADC_A_PART_LO 15'h0004
`define SNSADC_A_PART_HI 15'h0005
`define SNSADC_A_REV 15'h0006
`define SNSADC_A_MAKER_LO 15'h000C
`define SNSADC_A_MAKER_HI 15'h000D
`define SNSADC_A_COMMIT 15'h000F
`define SNSADC_A_BUFCFG 15'h0100
`define SNSADC_A_READY 15'h0103
`define SNSADC_A_VOLT_LO 15'h0200
`define SNSADC_A_VOLT_HI 15'h0201
`define SNSADC_A_AMP_LO 15'h0202
`define SNSADC_A_AMP_HI 15'h0203

// ==========================================================
// Field positions and fill values
`define SNSADC_BIT_RBSEL 5
`define SNSADC_BIT_COMMIT 0
`define SNSADC_BIT_CMD_READ 15
`define SNSADC_CFG_RESET 8'h00
`define SNSADC_BYTE_ZERO 8'h00
`define SNSADC_HI_PAD 4'h0
`define SNSADC_READY_PAD 7'h00
`define SNSADC_RESULT_RESET 12'h000

// ==========================================================
// Serial frame counts
`define SNSADC_CMD_LAST 4'hF
`define SNSADC_BYTE_LAST 4'h7
`define SNSADC_COUNT_ZERO 4'h0
`define SNSADC_COUNT_ONE 4'h1
`define SNSADC_ADDR_ONE 15'h0001

`endif

// [core/snsadc_pkg.sv]
// Purpose: Types shared by the sensor register bank and its serial link
// Assumes: Constants live in snsadc_consts.svh
// Notes: Request crosses from the serial clock to the core clock
package snsadc_pkg;

	// ==========================================================
	// Link request, held stable by the link between toggles
	typedef struct packed
	{
		logic write;
		logic prevDone;
		logic [14:0] addr;
		logic [7:0] data;
	} snsadc_req_type;

	// ==========================================================
	// One simultaneous conversion of both channels
	typedef struct packed
	{
		logic [11:0] volt;
		logic [11:0] amp;
	} snsadc_sample_type;

	// ==========================================================
	// Descending result read tracker
	typedef enum logic [4:0]
	{
		SEQ_OPEN = 5'b00001,
		SEQ_WAIT_AMP_HI = 5'b00010,
		SEQ_WAIT_AMP_LO = 5'b00100,
		SEQ_WAIT_VOLT_HI = 5'b01000,
		SEQ_WAIT_VOLT_LO = 5'b10000
	} snsadc_seq_type;

endpackage : snsadc_pkg

// [core/snsadc_toggle_sync.sv]
// Purpose: Carry a toggle event from the serial clock into the core clock
// Assumes: Toggle changes no faster than once per three core cycles
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module snsadc_toggle_sync (
	input wire logic clock,
	input wire logic rstn,
	input wire logic toggleIn,
	output logic pulse
);
	logic stage1;
	logic stage2;
	logic stage3;

	// ==========================================================
	// Two-flop synchroniser plus an edge stage
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end
		else
		begin
			stage1 <= toggleIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// One-cycle event per toggle
	assign pulse = stage2 ^ stage3;

endmodule : snsadc_toggle_sync

// [core/snsadc_spi_link.sv]
// Purpose: Four-wire serial slave on the serial clock: command, bytes, decrement
// Assumes: Mode 0, MSB first, 16-bit command with read flag on top
// Notes: Frame logic is cleared by the deselect level itself
`timescale 1ns/10ps
`include "snsadc_consts.svh"
module snsadc_spi_link (
	input wire logic serialClock,
	input wire logic chipSelectn,
	input wire logic serialIn,
	input wire logic linkClearn,
	input wire logic [7:0] rdData,
	output logic serialOut,
	output snsadc_pkg::snsadc_req_type req,
	output logic reqToggle
);
	import snsadc_pkg::*;

	logic [3:0] bitCount;
	logic inData;
	logic isRead;
	logic [14:0] addr;
	logic [14:0] shiftIn;
	logic [6:0] shiftOut;
	logic [15:0] cmdWord;
	logic [7:0] dataWord;
	logic cmdEnd;
	logic byteEnd;

	// Words as they stand including the bit on the wire now
	assign cmdWord = {shiftIn, serialIn};
	assign dataWord = {shiftIn[6:0], serialIn};
	assign cmdEnd = !inData && (bitCount == `SNSADC_CMD_LAST);
	assign byteEnd = inData && (bitCount == `SNSADC_BYTE_LAST);

	// ==========================================================
	// Frame counters; clock stands still while deselected
	always_ff @(posedge serialClock or posedge chipSelectn)
	begin
		if (chipSelectn)
		begin
			bitCount <= `SNSADC_COUNT_ZERO;
			inData <= 1'b0;
			isRead <= 1'b0;
			addr <= 15'h0000;
			shiftIn <= 15'h0000;
		end
		else
		begin
			shiftIn <= cmdWord[14:0];
			if (cmdEnd)
			begin
				inData <= 1'b1;
				bitCount <= `SNSADC_COUNT_ZERO;
				isRead <= cmdWord[`SNSADC_BIT_CMD_READ];
				addr <= cmdWord[14:0];
			end
			else if (byteEnd)
			begin
				// Auto-decrement, wrapping below zero
				bitCount <= `SNSADC_COUNT_ZERO;
				addr <= addr - `SNSADC_ADDR_ONE;
			end
			else
			begin
				bitCount <= bitCount + `SNSADC_COUNT_ONE;
			end
		end
	end

	// ==========================================================
	// Requests; the toggle survives deselect so no false event appears
	always_ff @(posedge serialClock or negedge linkClearn)
	begin
		if (!linkClearn)
		begin
			req <= '0;
			reqToggle <= 1'b0;
		end
		else if (cmdEnd && cmdWord[`SNSADC_BIT_CMD_READ])
		begin
			req <= '{write: 1'b0, prevDone: 1'b0, addr: cmdWord[14:0], data: `SNSADC_BYTE_ZERO};
			reqToggle <= !reqToggle;
		end
		else if (byteEnd && isRead)
		begin
			// Prefetch next address; also confirms the byte just shifted out
			req <= '{write: 1'b0, prevDone: 1'b1, addr: addr - `SNSADC_ADDR_ONE,
				data: `SNSADC_BYTE_ZERO};
			reqToggle <= !reqToggle;
		end
		else if (byteEnd)
		begin
			req <= '{write: 1'b1, prevDone: 1'b0, addr: addr, data: dataWord};
			reqToggle <= !reqToggle;
		end
	end

	// ==========================================================
	// Output shifter on the falling edge; loads at each read byte start
	always_ff @(negedge serialClock or posedge chipSelectn)
	begin
		if (chipSelectn)
		begin
			serialOut <= 1'b0;
			shiftOut <= 7'h00;
		end
		else if (inData && isRead && (bitCount == `SNSADC_COUNT_ZERO))
		begin
			{serialOut, shiftOut} <= rdData;
		end
		else
		begin
			{serialOut, shiftOut} <= {shiftOut, 1'b0};
		end
	end

endmodule : snsadc_spi_link

// [core/snsadc_register_bank.sv]
// Purpose: Byte register bank of a two-channel current and voltage monitor
// Assumes: Conversion samples arrive on the core clock with a strobe
// Notes: Serial link runs on its own clock; requests cross by toggle
//
// Function
// - Writing one to commit bit 0 copies buffered config into active config.
// - Commit bit clears itself, writing zero does nothing, resets to zero.
// - Buffered config byte is a read/write spare byte resetting to zero.
// - Ready register bit 0 shows converter ready; bits 7 to 1 read zero.
// - Voltage low byte returns result bits 7 to 0.
// - Voltage high byte returns result bits 11 to 8, upper nibble zero.
// - Current low byte returns result bits 7 to 0.
// - Current high byte returns result bits 11 to 8, upper nibble zero.
// - Read-only class, part, revision and maker codes at their own addresses.
// - Read-back selection affects only the buffered config byte.
// - Interface config bits 2 to 1 are read-only and read zero.
// - Read-back select clear returns active config, set returns buffered.
// - New results appear only after all four results read descending.
// - Each 12-bit code sits right-justified with upper four bits zero.
`timescale 1ns/10ps
`include "snsadc_consts.svh"
module snsadc_register_bank #(
	parameter logic [7:0] CLASS_CODE = 8'h3C, // Arbitrary value
	parameter logic [7:0] PART_LOW = 8'h5A, // Arbitrary value
	parameter logic [7:0] PART_HIGH = 8'hA5, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h6E, // Arbitrary value
	parameter logic [7:0] MAKER_LOW = 8'h92, // Arbitrary value
	parameter logic [7:0] MAKER_HIGH = 8'h2D // Arbitrary value
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic serialClock,
	input wire logic chipSelectn,
	input wire logic serialIn,
	output logic serialOut,
	input wire snsadc_pkg::snsadc_sample_type sample,
	input wire logic sampleStrobe,
	input wire logic converterReady,
	output logic [7:0] activeConfig
);
	import snsadc_pkg::*;

	logic linkClearn;
	logic reqToggle;
	logic reqFire;
	snsadc_req_type req;
	logic writeFire;
	logic readFire;
	logic doneFire;
	logic [14:0] doneAddr;
	logic [7:0] rdData;
	logic [7:0] next_rdData;
	logic [7:0] bufConfig;
	logic readbackSelect;
	logic commitPulse;
	snsadc_sample_type pending;
	logic pendingValid;
	snsadc_sample_type presented;
	snsadc_seq_type seqState;
	snsadc_seq_type next_seqState;
	logic transfer;

	// ==========================================================
	// Helpers
	function automatic logic isResultAddr(input logic [14:0] a);
		isResultAddr = (a == `SNSADC_A_VOLT_LO) || (a == `SNSADC_A_VOLT_HI) ||
			(a == `SNSADC_A_AMP_LO) || (a == `SNSADC_A_AMP_HI);
	endfunction : isResultAddr

	// Right-justified high byte of a 12-bit code
	function automatic logic [7:0] highByte(input logic [11:0] code);
		highByte = {`SNSADC_HI_PAD, code[11:8]};
	endfunction : highByte

	// ==========================================================
	// Serial link and crossing
	snsadc_spi_link link (
		.serialClock(serialClock),
		.chipSelectn(chipSelectn),
		.serialIn(serialIn),
		.linkClearn(linkClearn),
		.rdData(rdData),
		.serialOut(serialOut),
		.req(req),
		.reqToggle(reqToggle)
	);

	snsadc_toggle_sync reqSync (
		.clock(clock),
		.rstn(rstn),
		.toggleIn(reqToggle),
		.pulse(reqFire)
	);

	// Link request registers cleared while the core is in reset
	always_ff @(posedge clock)
	begin
		if (!rstn)
			linkClearn <= 1'b0;
		else
			linkClearn <= 1'b1;
	end

	// Request is stable here: it changed with the toggle, before the pulse
	assign writeFire = reqFire && req.write;
	assign readFire = reqFire && !req.write;
	assign doneFire = reqFire && req.prevDone;
	assign doneAddr = req.addr + `SNSADC_ADDR_ONE;

	// ==========================================================
	// Buffered config byte, host-writable
	always_ff @(posedge clock)
	begin
		if (!rstn)
			bufConfig <= `SNSADC_CFG_RESET;
		else if (writeFire && (req.addr == `SNSADC_A_BUFCFG))
			bufConfig <= req.data;
	end

	// Read-back select in the interface config register
	always_ff @(posedge clock)
	begin
		if (!rstn)
			readbackSelect <= 1'b0;
		else if (writeFire && (req.addr == `SNSADC_A_IFCFG))
			readbackSelect <= req.data[`SNSADC_BIT_RBSEL];
	end

	// Commit strobe lives one cycle; a written zero is no action
	always_ff @(posedge clock)
	begin
		if (!rstn)
			commitPulse <= 1'b0;
		else
			commitPulse <= writeFire && (req.addr == `SNSADC_A_COMMIT) &&
				req.data[`SNSADC_BIT_COMMIT];
	end

	// Active copy moves only on a commit
	always_ff @(posedge clock)
	begin
		if (!rstn)
			activeConfig <= `SNSADC_CFG_RESET;
		else if (commitPulse)
			activeConfig <= bufConfig;
	end

	// ==========================================================
	// Pending sample; both channels taken in the same cycle
	always_ff @(posedge clock)
	begin
		if (!rstn)
			pending <= '0;
		else if (sampleStrobe)
			pending <= sample;
	end

	assign transfer = (seqState == SEQ_OPEN) && pendingValid;

	// New sample wins over the transfer that consumes the old one
	always_ff @(posedge clock)
	begin
		if (!rstn)
			pendingValid <= 1'b0;
		else if (sampleStrobe)
			pendingValid <= 1'b1;
		else if (transfer)
			pendingValid <= 1'b0;
	end

	// Presented results frozen while a read walk is due
	always_ff @(posedge clock)
	begin
		if (!rstn)
			presented <= '{volt: `SNSADC_RESULT_RESET, amp: `SNSADC_RESULT_RESET};
		else if (transfer)
			presented <= pending;
	end

	// ==========================================================
	// Descending walk tracker; a wrong result read restarts the walk
	always_comb
	begin
		next_seqState = (doneAddr == `SNSADC_A_AMP_HI) ? SEQ_WAIT_AMP_LO : SEQ_WAIT_AMP_HI;
		case (seqState)
			SEQ_WAIT_AMP_LO:
				if (doneAddr == `SNSADC_A_AMP_LO)
					next_seqState = SEQ_WAIT_VOLT_HI;
			SEQ_WAIT_VOLT_HI:
				if (doneAddr == `SNSADC_A_VOLT_HI)
					next_seqState = SEQ_WAIT_VOLT_LO;
			SEQ_WAIT_VOLT_LO:
				if (doneAddr == `SNSADC_A_VOLT_LO)
					next_seqState = SEQ_OPEN;
			default:
				next_seqState = next_seqState;
		endcase
	end

	// Only fully shifted bytes count, so a prefetch never advances it
	always_ff @(posedge clock)
	begin
		if (!rstn)
			seqState <= SEQ_OPEN;
		else if (transfer)
			seqState <= SEQ_WAIT_AMP_HI;
		else if ((seqState != SEQ_OPEN) && doneFire && isResultAddr(doneAddr))
			seqState <= next_seqState;
	end

	// ==========================================================
	// Read decode; unmapped addresses read zero
	always_comb
	begin
		next_rdData = `SNSADC_BYTE_ZERO;
		if (req.addr == `SNSADC_A_IFCFG)
			next_rdData[`SNSADC_BIT_RBSEL] = readbackSelect;
		else if (req.addr == `SNSADC_A_CLASS)
			next_rdData = CLASS_CODE;
		else if (req.addr == `SNSADC_A_PART_LO)
			next_rdData = PART_LOW;
		else if (req.addr == `SNSADC_A_PART_HI)
			next_rdData = PART_HIGH;
		else if (req.addr == `SNSADC_A_REV)
			next_rdData = REVISION;
		else if (req.addr == `SNSADC_A_MAKER_LO)
			next_rdData = MAKER_LOW;
		else if (req.addr == `SNSADC_A_MAKER_HI)
			next_rdData = MAKER_HIGH;
		else if (req.addr == `SNSADC_A_COMMIT)
			next_rdData[`SNSADC_BIT_COMMIT] = commitPulse;
		else if (req.addr == `SNSADC_A_BUFCFG)
			next_rdData = readbackSelect ? bufConfig : activeConfig;
		else if (req.addr == `SNSADC_A_READY)
			next_rdData = {`SNSADC_READY_PAD, converterReady};
		else if (req.addr == `SNSADC_A_VOLT_LO)
			next_rdData = presented.volt[7:0];
		else if (req.addr == `SNSADC_A_VOLT_HI)
			next_rdData = highByte(presented.volt);
		else if (req.addr == `SNSADC_A_AMP_LO)
			next_rdData = presented.amp[7:0];
		else if (req.addr == `SNSADC_A_AMP_HI)
			next_rdData = highByte(presented.amp);
	end

	// Held until the next read request; link loads it half a bit later
	always_ff @(posedge clock)
	begin
		if (!rstn)
			rdData <= `SNSADC_BYTE_ZERO;
		else if (readFire)
			rdData <= next_rdData;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence sCommitWrite;
		writeFire && (req.addr == `SNSADC_A_COMMIT) && req.data[`SNSADC_BIT_COMMIT];
	endsequence

	sequence sReadOf(logic [14:0] a);
		readFire && (req.addr == a);
	endsequence

	sequence sLastResultDone;
		(seqState == SEQ_WAIT_VOLT_LO) && doneFire && (doneAddr == `SNSADC_A_VOLT_LO);
	endsequence

	a_commit_copy: assert property (sCommitWrite ##1 1'b1 |=> activeConfig == $past(bufConfig))
		else $error("active config not loaded from buffer after commit");

	a_commit_clears: assert property (sCommitWrite |=> commitPulse ##1 !commitPulse)
		else $error("commit bit did not self clear");

	a_active_holds: assert property (!commitPulse |=> $stable(activeConfig))
		else $error("active config changed without commit");

	a_buffer_reset: assert property (@(posedge clock) disable iff (1'b0)
		!rstn |=> bufConfig == `SNSADC_CFG_RESET)
		else $error("buffered config not zero after reset");

	a_ready_read: assert property (sReadOf(`SNSADC_A_READY) |=>
		rdData == {`SNSADC_READY_PAD, $past(converterReady)})
		else $error("ready register wrong");

	a_volt_low: assert property (sReadOf(`SNSADC_A_VOLT_LO) |=>
		rdData == $past(presented.volt[7:0]))
		else $error("voltage low byte wrong");

	a_volt_high: assert property (sReadOf(`SNSADC_A_VOLT_HI) |=>
		rdData[7:4] == `SNSADC_HI_PAD && rdData[3:0] == $past(presented.volt[11:8]))
		else $error("voltage high byte wrong");

	a_amp_low: assert property (sReadOf(`SNSADC_A_AMP_LO) |=>
		rdData == $past(presented.amp[7:0]))
		else $error("current low byte wrong");

	a_amp_high: assert property (sReadOf(`SNSADC_A_AMP_HI) |=>
		rdData[7:4] == `SNSADC_HI_PAD && rdData[3:0] == $past(presented.amp[11:8]))
		else $error("current high byte wrong");

	a_class_code: assert property (sReadOf(`SNSADC_A_CLASS) |=> rdData == CLASS_CODE)
		else $error("class code wrong");

	a_readback_mux: assert property (sReadOf(`SNSADC_A_BUFCFG) |=>
		rdData == ($past(readbackSelect) ? $past(bufConfig) : $past(activeConfig)))
		else $error("config read-back selection wrong");

	a_ifcfg_reserved: assert property (sReadOf(`SNSADC_A_IFCFG) |=> rdData[2:1] == 2'b00)
		else $error("reserved interface bits not zero");

	a_result_frozen: assert property ((seqState != SEQ_OPEN) |=> $stable(presented))
		else $error("results changed during a read walk");

	a_walk_reopens: assert property (sLastResultDone ##1 pendingValid |=>
		seqState == SEQ_WAIT_AMP_HI && presented == $past(pending))
		else $error("new results not presented after full walk");

endmodule : snsadc_register_bank

// [verification/snsadc_spi_host.sv]
// Purpose: Serial host model driving the four-wire link of the register bank
// Assumes: Mode 0, MSB first, 16-bit command then data bytes
// Notes: Serial clock stands still outside frames
`timescale 1ns/10ps
module snsadc_spi_host (
	output logic serialClock,
	output logic chipSelectn,
	output logic serialIn,
	input wire logic serialOut
);
	// ==========================================================
	// Idle levels; deselected until the bench starts a frame
	initial
	begin
		serialClock = 1'b0;
		chipSelectn = 1'b1;
		serialIn = 1'b0;
	end

	// ==========================================================
	// One frame: command, nb bytes out of wd (first byte on top), read bits into rd
	task automatic frame(input logic [15:0] cmd, input int nb, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [47:0] sh;
		sh = {cmd, wd};
		rd = 32'h0000_0000;
		chipSelectn = 1'b0;
		#40;
		for (int i = 0; i < 16 + 8 * nb; i++)
		begin
			// Data changes on fall, held across the rise
			serialIn = sh[47];
			sh = sh << 1;
			#62.5 serialClock = 1'b1;
			if (i >= 16)
				rd = {rd[30:0], serialOut};
			#62.5 serialClock = 1'b0;
		end
		#40;
		chipSelectn = 1'b1;
		// Idle data line flips so a stale bit is never mistaken for data
		serialIn = ~serialIn;
		// Deselect gap, so back-to-back frames never glue select low
		#100;
	endtask : frame
endmodule : snsadc_spi_host

// [verification/snsadc_register_bank_tb_top.sv]
// Purpose: Self-checking bench of the sensor register bank
// Assumes: Host model owns the link pins; bench owns core-side inputs
// Notes: Id bytes set to bench values so a hard-wired constant shows up
`timescale 1ns/10ps
`include "snsadc_consts.svh"
module snsadc_register_bank_tb_top;
	import snsadc_pkg::*;
	localparam logic [7:0] ID_CLASS = 8'h71; // Arbitrary value
	localparam logic [7:0] ID_PLO = 8'h2E; // Arbitrary value
	localparam logic [7:0] ID_PHI = 8'hC3; // Arbitrary value
	localparam logic [7:0] ID_REV = 8'h19; // Arbitrary value
	localparam logic [7:0] ID_MLO = 8'hB6; // Arbitrary value
	localparam logic [7:0] ID_MHI = 8'h4D; // Arbitrary value
	logic clock;
	logic rstn;
	logic serialClock;
	logic chipSelectn;
	logic serialIn;
	logic serialOut;
	logic sampleStrobe;
	logic converterReady;
	logic [7:0] activeConfig;
	snsadc_sample_type sample;
	logic [31:0] rd;
	int fail_count;
	int total_checks;
	int cycleCount;

	// ==========================================================
	// Design and host
	snsadc_register_bank #(.CLASS_CODE(ID_CLASS), .PART_LOW(ID_PLO), .PART_HIGH(ID_PHI),
		.REVISION(ID_REV), .MAKER_LOW(ID_MLO), .MAKER_HIGH(ID_MHI)) DUT (
		.clock(clock), .rstn(rstn), .serialClock(serialClock), .chipSelectn(chipSelectn),
		.serialIn(serialIn), .serialOut(serialOut), .sample(sample),
		.sampleStrobe(sampleStrobe), .converterReady(converterReady),
		.activeConfig(activeConfig));
	snsadc_spi_host host (.serialClock(serialClock), .chipSelectn(chipSelectn),
		.serialIn(serialIn), .serialOut(serialOut));

	// ==========================================================
	// Core clock, 200 MHz
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Hang guard; the full run needs well under half of this
	always @(posedge clock)
	begin
		cycleCount <= cycleCount + 1;
		if (cycleCount == 80000)
		begin
			fail_count++;
			test_done();
		end
	end

	// ==========================================================
	// Helpers
	task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check8

	task rdchk(input string what, input logic [14:0] a, input logic [7:0] exp);
		host.frame({1'b1, a}, 1, 32'h0000_0000, rd);
		check8(what, exp, rd[7:0]);
	endtask : rdchk

	task wr1(input logic [14:0] a, input logic [7:0] d);
		host.frame({1'b0, a}, 1, {d, 24'h00_0000}, rd);
	endtask : wr1

	task strobe(input logic [11:0] v, input logic [11:0] a);
		@(posedge clock);
		sample <= '{volt: v, amp: a};
		sampleStrobe <= 1'b1;
		@(posedge clock);
		sampleStrobe <= 1'b0;
	endtask : strobe

	// Descending four-byte read from the current high byte
	task read_all(input logic [11:0] v, input logic [11:0] a);
		host.frame({1'b1, `SNSADC_A_AMP_HI}, 4, 32'h0000_0000, rd);
		check8("amp_sample_high", {4'h0, a[11:8]}, rd[31:24]);
		check8("amp_sample_low", a[7:0], rd[23:16]);
		check8("volt_sample_high", {4'h0, v[11:8]}, rd[15:8]);
		check8("volt_sample_low", v[7:0], rd[7:0]);
	endtask : read_all

	// ==========================================================
	// Identity bytes, ready flag, unmapped and read-only places
	task t_ids;
		host.frame({1'b1, `SNSADC_A_REV}, 4, 32'h0000_0000, rd);
		check8("revision_code", ID_REV, rd[31:24]);
		check8("part_code_high", ID_PHI, rd[23:16]);
		check8("part_code_low", ID_PLO, rd[15:8]);
		check8("device_class_code", ID_CLASS, rd[7:0]);
		host.frame({1'b1, `SNSADC_A_MAKER_HI}, 2, 32'h0000_0000, rd);
		check8("maker_code_high", ID_MHI, rd[15:8]);
		check8("maker_code_low", ID_MLO, rd[7:0]);
		wr1(`SNSADC_A_CLASS, 8'hFF);
		rdchk("class after write", `SNSADC_A_CLASS, ID_CLASS);
		rdchk("unmapped", 15'h0002, 8'h00);
		rdchk("readiness_flags high", `SNSADC_A_READY, 8'h01);
		@(posedge clock);
		converterReady <= 1'b0;
		rdchk("readiness_flags low", `SNSADC_A_READY, 8'h00);
		@(posedge clock);
		converterReady <= 1'b1;
	endtask : t_ids

	// ==========================================================
	// Buffered config, commit strobe and read-back selection
	task t_config;
		rdchk("buffered reset", `SNSADC_A_BUFCFG, 8'h00);
		rdchk("commit reset", `SNSADC_A_COMMIT, 8'h00);
		wr1(`SNSADC_A_BUFCFG, 8'hA5);
		repeat (10) @(posedge clock);
		check8("active before commit", 8'h00, activeConfig);
		rdchk("readback active", `SNSADC_A_BUFCFG, 8'h00);
		wr1(`SNSADC_A_IFCFG, 8'hFF);
		rdchk("interface config", `SNSADC_A_IFCFG, 8'h20);
		rdchk("readback buffered", `SNSADC_A_BUFCFG, 8'hA5);
		rdchk("ready under select", `SNSADC_A_READY, 8'h01);
		wr1(`SNSADC_A_COMMIT, 8'h00);
		repeat (10) @(posedge clock);
		check8("active after zero", 8'h00, activeConfig);
		wr1(`SNSADC_A_COMMIT, 8'h01);
		repeat (10) @(posedge clock);
		check8("active after commit", 8'hA5, activeConfig);
		rdchk("commit self clear", `SNSADC_A_COMMIT, 8'h00);
		wr1(`SNSADC_A_BUFCFG, 8'h3C);
		wr1(`SNSADC_A_IFCFG, 8'h00);
		rdchk("readback active new", `SNSADC_A_BUFCFG, 8'hA5);
		repeat (10) @(posedge clock);
		check8("active holds", 8'hA5, activeConfig);
	endtask : t_config

	// ==========================================================
	// Result pairing, freezing and the descending read walk
	task t_results;
		strobe(12'hABC, 12'h5E7);
		strobe(12'h123, 12'hF0D);
		read_all(12'hABC, 12'h5E7);
		read_all(12'h123, 12'hF0D);
		// Walk is complete, so this pair shows at once; the next one waits
		strobe(12'h9F1, 12'h6A2);
		strobe(12'h456, 12'h789);
		rdchk("partial high", `SNSADC_A_AMP_HI, 8'h06);
		rdchk("out of order", `SNSADC_A_VOLT_LO, 8'hF1);
		read_all(12'h9F1, 12'h6A2);
		read_all(12'h456, 12'h789);
	endtask : t_results

	// ==========================================================
	// Closing report
	task test_done;
		$display("Checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// ==========================================================
	// Main sequence
	initial
	begin
		fail_count = 0;
		total_checks = 0;
		cycleCount = 0;
		rstn = 1'b0;
		sampleStrobe = 1'b0;
		converterReady = 1'b1;
		sample = '{volt: 12'h000, amp: 12'h000};
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		check8("active reset", 8'h00, activeConfig);
		t_ids();
		t_config();
		t_results();
		test_done();
	end
endmodule : snsadc_register_bank_tb_top
